// file: design/lsmpc_defs.vh
`ifndef LSMPC_DEFS_VH
`define LSMPC_DEFS_VH

// ****************************************************************
// Command word layout
// ****************************************************************
`define LSMPC_WD_BIT          15
`define LSMPC_ADDR_HI         14
`define LSMPC_ADDR_LO         12
`define LSMPC_ADDR_CTRL       3'h0
`define LSMPC_ADDR_CH0        3'h1
`define LSMPC_ADDR_CAL        3'h5
`define LSMPC_CAL_WORD        12'ha5c

// Control register fields
`define LSMPC_ON_LO           0
`define LSMPC_DIRDIS_LO       4
`define LSMPC_PWMEN_BIT       8
`define LSMPC_CLKSEL_BIT      9
`define LSMPC_OVOFF_BIT       10
`define LSMPC_VDDEN_BIT       11

// Channel register fields
`define LSMPC_DUTY_LO         0
`define LSMPC_DELAY_LO        7

// Reset values
`define LSMPC_CTRL_RST        12'h000
`define LSMPC_CH_RST          10'h000

// ****************************************************************
// Timing
// ****************************************************************
`define LSMPC_WORD_BITS       5'h10
`define LSMPC_PWM_STEPS       128
`define LSMPC_DELAY_STEP      16
`define LSMPC_WATCHDOG_TIMEOUT_PERIOD_CYC        1000000
`define LSMPC_INT_DEF_CYC     3906
`define LSMPC_CAL_MIN_CYC     349952
`define LSMPC_CAL_MAX_CYC     649984
`define LSMPC_EXT_MIN_CYC     1953
`define LSMPC_EXT_MAX_CYC     7812

`endif

// file: design/lsmpc_core.v
`timescale 1ns/1ps
// Overview of operation
// - SPI words are 16 bits, MSB first
// - Exactly one of four modes at once
// - Wake is reset, wake or input-on OR
// - Fail from supply loss or watchdog timeout
// - Fault is OR of all trip flags, low supply and gated high supply
// - No wake means sleep, outputs off
// - Mode chosen from wake, fail, fault terms
// - Sleep clears every configurable setting
// - Normal-mode flag high only in normal
// - Drive request from input, on-bit, PWM
// - Fault rearm from input-on or on-bit
// - PWM drives output, other inputs ignored
// - PWM period is 128 selected clock cycles
// - Duty code n gives (n+1)/128 high
// - Delay code k shifts by 16k edges
// - Bad external clock stops PWM, flags it
// - Calibration word then chip-select low pulse
// - Out-of-range calibration pulse is discarded
// - Select bit picks calibrated internal clock
// - Watchdog armed by rising wake terms
// - Host toggles bit 15 before timeout
// - Fail-safe until bit 15 one, supply good
// - Fail-safe: inputs drive, settings default
// - Sample on falling, shift on rising
// - Status loads on select low, commit high
`include "lsmpc_defs.vh"

module lsmpc_core #(
    parameter integer WATCHDOG_TIMEOUT_PERIOD_CYC    = `LSMPC_WATCHDOG_TIMEOUT_PERIOD_CYC,
    parameter integer INT_DEF_CYC = `LSMPC_INT_DEF_CYC,
    parameter integer CAL_MIN_CYC = `LSMPC_CAL_MIN_CYC,
    parameter integer CAL_MAX_CYC = `LSMPC_CAL_MAX_CYC,
    parameter integer EXT_MIN_CYC = `LSMPC_EXT_MIN_CYC,
    parameter integer EXT_MAX_CYC = `LSMPC_EXT_MAX_CYC
) (
    input  wire        core_clk,
    input  wire        rstn,
    input  wire        spiCsN,
    input  wire        spiSclk,
    input  wire        spiSi,
    output reg         spiSo,
    output reg         spiSoEn,
    input  wire        wakePin,
    input  wire        resetPin,
    input  wire [3:0]  parIn,
    input  wire        failsafeSelectPin,
    input  wire        vddFail,
    input  wire [3:0]  currentTripFlags,
    input  wire [3:0]  thermalTripFlags,
    input  wire [3:0]  shortTripFlags,
    input  wire        lowSupplyFlag,
    input  wire        highSupplyFlag,
    output reg  [3:0]  loadSwitchOutputs,
    output reg  [3:0]  faultRearm,
    output reg  [3:0]  modeState,
    output reg         normalModeFlag,
    output reg         clockFailFlag
);

    localparam [3:0] MODE_SLEEP  = 4'b0001;
    localparam [3:0] MODE_NORMAL = 4'b0010;
    localparam [3:0] MODE_FSAFE  = 4'b0100;
    localparam [3:0] MODE_FAULT  = 4'b1000;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    reg  [24:0] syncA;
    reg  [24:0] syncB;
    always @(posedge core_clk) begin
        if (!rstn) begin
            syncA <= 25'h0000001;
            syncB <= 25'h0000001;
        end else begin
            syncA <= {highSupplyFlag, lowSupplyFlag, shortTripFlags, thermalTripFlags,
                      currentTripFlags, vddFail, failsafeSelectPin, parIn, resetPin,
                      wakePin, spiSi, spiSclk, spiCsN};
            syncB <= syncA;
        end
    end
    wire       csN     = syncB[0];
    wire       sclk    = syncB[1];
    wire       si      = syncB[2];
    wire       wakeS   = syncB[3];
    wire       rstS    = syncB[4];
    wire [3:0] inOn    = syncB[8:5];
    wire       fsiOpen = syncB[9];
    wire       vddBad  = syncB[10];
    wire [3:0] curT    = syncB[14:11];
    wire [3:0] thrT    = syncB[18:15];
    wire [3:0] shtT    = syncB[22:19];
    wire       lowS    = syncB[23];
    wire       highS   = syncB[24];

    reg        csPrev;
    reg        sclkPrev;
    reg        extPrev;
    reg  [5:0] wakePrev;
    wire       csFall   = csPrev & ~csN;
    wire       csRise   = ~csPrev & csN;
    wire       sclkRise = ~csN & ~sclkPrev & sclk;
    wire       sclkFall = ~csN & sclkPrev & ~sclk;
    wire       extRise  = ~extPrev & inOn[0];

    // ************************************************************
    // Mode terms
    // ************************************************************
    reg  [11:0] ctrl;
    reg  [9:0]  chCfg [0:3];
    reg         failState;
    reg         calValid;
    wire [3:0]  onBit   = ctrl[`LSMPC_ON_LO +: 4];
    wire [3:0]  dirDis  = ctrl[`LSMPC_DIRDIS_LO +: 4];
    wire        pwmEn   = ctrl[`LSMPC_PWMEN_BIT];
    wire        clkSel  = ctrl[`LSMPC_CLKSEL_BIT];
    wire        highSupplyGuardOff = ctrl[`LSMPC_OVOFF_BIT];
    wire        vddEn   = ctrl[`LSMPC_VDDEN_BIT];
    wire        wakeUp  = rstS | wakeS | (|inOn);
    wire        faultT  = (|curT) | (|thrT) | (|shtT) | lowS | (highS & highSupplyGuardOff);
    wire [3:0]  chTrip  = curT | thrT | shtT;
    wire        failT   = failState | (vddBad & vddEn);
    wire [3:0]  next_mode = !wakeUp ? MODE_SLEEP :
                            faultT  ? MODE_FAULT :
                            failT   ? MODE_FSAFE : MODE_NORMAL;

    // ************************************************************
    // SPI shifter
    // ************************************************************
    reg  [15:0] txReg;
    reg  [15:0] rxReg;
    reg  [4:0]  bitCnt;
    reg         calArmed;
    reg         calMeas;
    wire [15:0] statusWord = {normalModeFlag, clockFailFlag, modeState[3] | modeState[2],
                              modeState[3] | modeState[1], lowS, highS, failState, calValid,
                              curT | shtT, thrT};
    wire [2:0]  rxAddr = rxReg[`LSMPC_ADDR_HI:`LSMPC_ADDR_LO];
    // commit on select rising after a whole word
    wire        commit = csRise & (bitCnt == `LSMPC_WORD_BITS) & ~calMeas;
    wire        wdBit  = rxReg[`LSMPC_WD_BIT];

    always @(posedge core_clk) begin
        if (!rstn) begin
            txReg   <= 16'h0000;
            rxReg   <= 16'h0000;
            bitCnt  <= 5'h00;
            spiSo   <= 1'b0;
            spiSoEn <= 1'b0;
        end else begin
            spiSoEn <= ~csN;
            if (csFall) begin
                // status captured at select low
                // Bit 15 is already on the pin, so the first rise must show bit 14
                txReg  <= {statusWord[14:0], 1'b0};
                spiSo  <= statusWord[15];
                bitCnt <= 5'h00;
            end else begin
                if (sclkRise) begin
                    spiSo <= txReg[15];
                    txReg <= {txReg[14:0], 1'b0};
                end
                if (sclkFall) begin
                    rxReg <= {rxReg[14:0], si};
                    if (bitCnt != 5'h1f)
                        bitCnt <= bitCnt + 5'h01;
                end
            end
        end
    end

    // ************************************************************
    // Settings, watchdog and fail-safe
    // ************************************************************
    reg  [19:0] wdCnt;
    reg         wdArmed;
    reg         lastWd;
    wire        wdTimeout = wdArmed & (wdCnt == WATCHDOG_TIMEOUT_PERIOD_CYC[19:0] - 20'h00001);
    wire        wakeRise  = |({wakeS, rstS, inOn} & ~wakePrev);
    integer     ci;

    always @(posedge core_clk) begin
        if (!rstn) begin
            ctrl      <= `LSMPC_CTRL_RST;
            for (ci = 0; ci < 4; ci = ci + 1)
                chCfg[ci] <= `LSMPC_CH_RST;
            failState <= 1'b0;
            wdArmed   <= 1'b0;
            wdCnt     <= 20'h00000;
            lastWd    <= 1'b0;
            calArmed  <= 1'b0;
        end else if (!wakeUp) begin
            ctrl      <= `LSMPC_CTRL_RST;
            for (ci = 0; ci < 4; ci = ci + 1)
                chCfg[ci] <= `LSMPC_CH_RST;
            failState <= 1'b0;
            wdArmed   <= 1'b0;
            wdCnt     <= 20'h00000;
            lastWd    <= 1'b0;
            calArmed  <= 1'b0;
        end else begin
            if (!fsiOpen)
                wdArmed <= 1'b0;
            else if (wakeRise)
                wdArmed <= 1'b1;
            // host toggle of bit 15 feeds the watchdog
            if (commit && (wdBit != lastWd))
                wdCnt <= 20'h00000;
            else if (wdArmed && !failState && !wdTimeout)
                wdCnt <= wdCnt + 20'h00001;
            if (commit)
                lastWd <= wdBit;
            // leave fail-safe on bit 15 one, supply good
            if (wdTimeout || (vddBad && vddEn))
                failState <= 1'b1;
            else if (!vddBad && ((commit && wdBit) || !fsiOpen))
                failState <= 1'b0;
            if (failT) begin
                ctrl <= `LSMPC_CTRL_RST;
                for (ci = 0; ci < 4; ci = ci + 1)
                    chCfg[ci] <= `LSMPC_CH_RST;
                wdCnt <= 20'h00000;
            end else if (commit) begin
                if (rxAddr == `LSMPC_ADDR_CTRL)
                    ctrl <= rxReg[11:0];
                for (ci = 0; ci < 4; ci = ci + 1)
                    if (rxAddr == `LSMPC_ADDR_CH0 + ci[2:0])
                        chCfg[ci] <= rxReg[9:0];
            end
            // calibration word arms the pulse measurement
            if (commit && rxAddr == `LSMPC_ADDR_CAL && rxReg[11:0] == `LSMPC_CAL_WORD)
                calArmed <= 1'b1;
            else if (calMeas && csRise)
                calArmed <= 1'b0;
        end
    end

    // ************************************************************
    // Internal clock calibration
    // ************************************************************
    reg  [19:0] calWidth;
    reg  [12:0] intPeriod;
    reg  [12:0] intCnt;
    always @(posedge core_clk) begin
        if (!rstn || !wakeUp) begin
            calMeas   <= 1'b0;
            calWidth  <= 20'h00000;
            calValid  <= 1'b0;
            intPeriod <= INT_DEF_CYC[12:0];
        end else begin
            if (calArmed && csFall) begin
                calMeas  <= 1'b1;
                calWidth <= 20'h00000;
            end else if (calMeas && csRise) begin
                calMeas <= 1'b0;
                // keep old period if out of range
                if (calWidth >= CAL_MIN_CYC[19:0] && calWidth <= CAL_MAX_CYC[19:0]) begin
                    intPeriod <= calWidth[19:7];
                    calValid  <= 1'b1;
                end
            end else if (calMeas && calWidth != 20'hfffff) begin
                calWidth <= calWidth + 20'h00001;
            end
        end
    end

    // ************************************************************
    // PWM clock select, monitor and phase
    // ************************************************************
    reg  [15:0] extCnt;
    reg  [6:0]  phase;
    wire        intTick = (intCnt >= intPeriod - 13'h0001);
    wire        pwmTick = clkSel ? intTick : extRise;
    // PWM runs only with a good clock
    wire        pwmRun  = pwmEn & (clkSel | ~clockFailFlag);

    always @(posedge core_clk) begin
        if (!rstn) begin
            intCnt        <= 13'h0000;
            extCnt        <= 16'h0000;
            clockFailFlag <= 1'b0;
            phase         <= 7'h00;
        end else begin
            intCnt <= intTick ? 13'h0000 : intCnt + 13'h0001;
            // period window check on external clock
            if (extRise) begin
                extCnt        <= 16'h0000;
                clockFailFlag <= (extCnt < EXT_MIN_CYC[15:0]) | (extCnt > EXT_MAX_CYC[15:0]);
            end else if (extCnt != 16'hffff) begin
                extCnt <= extCnt + 16'h0001;
                if (extCnt > EXT_MAX_CYC[15:0])
                    clockFailFlag <= 1'b1;
            end
            if (!pwmRun)
                phase <= 7'h00;
            else if (pwmTick)
                phase <= phase + 7'h01;
        end
    end

    // ************************************************************
    // Per-channel drive
    // ************************************************************
    wire [3:0] next_hson;
    wire [3:0] next_rearm;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gChan
            // delay by 16 edges per step
            wire [6:0] shifted = phase - {chCfg[g][`LSMPC_DELAY_LO +: 3], 4'h0};
            // high for (n+1) of 128 steps
            wire       wave    = (shifted <= chCfg[g][`LSMPC_DUTY_LO +: 7]);
            assign next_hson[g]  = pwmEn ? (onBit[g] & (wave | ~pwmRun))
                                         : ((inOn[g] & ~dirDis[g]) | onBit[g]);
            assign next_rearm[g] = (inOn[g] & ~dirDis[g] & ~pwmEn) | onBit[g];
        end
    endgenerate

    always @(posedge core_clk) begin
        if (!rstn) begin
            csPrev            <= 1'b1;
            sclkPrev          <= 1'b0;
            extPrev           <= 1'b0;
            wakePrev          <= 6'h00;
            modeState         <= MODE_SLEEP;
            normalModeFlag    <= 1'b0;
            loadSwitchOutputs <= 4'h0;
            faultRearm        <= 4'h0;
        end else begin
            csPrev         <= csN;
            sclkPrev       <= sclk;
            extPrev        <= inOn[0];
            wakePrev       <= {wakeS, rstS, inOn};
            modeState      <= next_mode;
            normalModeFlag <= (next_mode == MODE_NORMAL);
            case (next_mode)
                MODE_SLEEP: begin
                    loadSwitchOutputs <= 4'h0;
                    faultRearm        <= 4'h0;
                end
                MODE_FAULT: begin
                    loadSwitchOutputs <= next_hson & ~chTrip
                                         & {4{~lowS & ~(highS & highSupplyGuardOff)}};
                    faultRearm        <= next_rearm;
                end
                MODE_FSAFE: begin
                    loadSwitchOutputs <= inOn;
                    faultRearm        <= inOn;
                end
                default: begin
                    loadSwitchOutputs <= next_hson;
                    faultRearm        <= next_rearm;
                end
            endcase
        end
    end

endmodule // lsmpc_core

// file: tb/lsmpc_host_model.sv
`timescale 1ns/1ps
// ********************************
// Host side of the serial link
// ********************************
module lsmpc_host_model (
    input  wire         core_clk,
    output logic        spiCsN,
    output logic        spiSclk,
    output logic        spiSi,
    input  wire         spiSo
);
    // Idle levels match the pin pulls: select high, clock and data low
    initial begin
        spiCsN = 1'b1;
        spiSclk = 1'b0;
        spiSi = 1'b0;
    end

    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(negedge core_clk);
        spiCsN = 1'b0;
        repeat (8) @(negedge core_clk);
        for (int i = 15; i >= 0; i--) begin
            // Read before the rise, since the rise moves the next bit out
            rx[i] = spiSo;
            spiSi = tx[i];
            spiSclk = 1'b1;
            repeat (4) @(negedge core_clk);
            spiSclk = 1'b0;
            repeat (4) @(negedge core_clk);
        end
        spiSi = 1'b0;
        spiCsN = 1'b1;
        repeat (8) @(negedge core_clk);
    endtask

    // select low pulse measured after the calibration word
    task automatic calPulse(input int n);
        @(negedge core_clk);
        spiCsN = 1'b0;
        repeat (n) @(negedge core_clk);
        spiCsN = 1'b1;
        repeat (8) @(negedge core_clk);
    endtask
endmodule // lsmpc_host_model

// file: tb/lsmpc_core_checker.sv
`timescale 1ns/1ps
// ********************************
// Mode and output relations
// ********************************
module lsmpc_core_checker (
    input wire       core_clk,
    input wire       rstn,
    input wire       spiCsN,
    input wire       spiSoEn,
    input wire       wakePin,
    input wire       resetPin,
    input wire [3:0] parIn,
    input wire [3:0] currentTripFlags,
    input wire [3:0] loadSwitchOutputs,
    input wire [3:0] modeState,
    input wire       normalModeFlag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_oneMode; $onehot(modeState); endproperty
    a_oneMode: assert property (p_oneMode) else $error("mode not one-hot");

    property p_sleepOff; modeState == 4'h1 |-> loadSwitchOutputs == 4'h0; endproperty
    a_sleepOff: assert property (p_sleepOff) else $error("output on in sleep");

    property p_nmFlag; normalModeFlag == (modeState == 4'h2); endproperty
    a_nmFlag: assert property (p_nmFlag) else $error("normal flag wrong");

    property p_noWake;
        (!wakePin && !resetPin && parIn == 4'h0) [*8] |=> modeState == 4'h1;
    endproperty
    a_noWake: assert property (p_noWake) else $error("awake without wake term");

    property p_fault; (wakePin && currentTripFlags != 4'h0) [*6] |=> modeState == 4'h8;
    endproperty
    a_fault: assert property (p_fault) else $error("trip without fault mode");

    property p_soIdle; spiCsN [*6] |-> !spiSoEn; endproperty
    a_soIdle: assert property (p_soIdle) else $error("driver on while deselected");

    property p_soOn; !spiCsN [*6] |-> spiSoEn; endproperty
    a_soOn: assert property (p_soOn) else $error("driver off while selected");

    property p_failsafeOut;
        (modeState == 4'h4 && $stable(parIn)) [*6] |-> loadSwitchOutputs == parIn;
    endproperty
    a_failsafeOut: assert property (p_failsafeOut) else $error("fail-safe output");
endmodule // lsmpc_core_checker

bind lsmpc_core lsmpc_core_checker chk (
    .core_clk         (core_clk),
    .rstn             (rstn),
    .spiCsN           (spiCsN),
    .spiSoEn          (spiSoEn),
    .wakePin          (wakePin),
    .resetPin         (resetPin),
    .parIn            (parIn),
    .currentTripFlags (currentTripFlags),
    .loadSwitchOutputs(loadSwitchOutputs),
    .modeState        (modeState),
    .normalModeFlag   (normalModeFlag)
);

// file: tb/lsmpc_core_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module lsmpc_core_bench;
    // Watchdog shortened so the timeout fits the run
    localparam integer WATCHDOG_TIMEOUT_PERIOD = 2000;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic wakePin = 1'b0;
    logic resetPin = 1'b0;
    logic [3:0] parIn = 4'h0;
    logic fsPin = 1'b0;
    logic [3:0] tripOc = 4'h0;
    logic zero1 = 1'b0;
    logic [3:0] zero4 = 4'h0;
    wire spiCsN, spiSclk, spiSi, spiSo, spiSoEn, nmFlag, clkFail;
    wire [3:0] outs, rearm, modeState;
    logic [15:0] rxWord;
    int testsRun = 0;
    int miscompares = 0;
    int cnt;

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    lsmpc_host_model host (.core_clk(core_clk), .spiCsN(spiCsN), .spiSclk(spiSclk),
        .spiSi(spiSi), .spiSo(spiSo));

    lsmpc_core #(.WATCHDOG_TIMEOUT_PERIOD_CYC(WATCHDOG_TIMEOUT_PERIOD), .INT_DEF_CYC(4), .CAL_MIN_CYC(400),
        .CAL_MAX_CYC(1000)) uut (
        .core_clk(core_clk), .rstn(rstn), .spiCsN(spiCsN), .spiSclk(spiSclk),
        .spiSi(spiSi), .spiSo(spiSo), .spiSoEn(spiSoEn), .wakePin(wakePin),
        .resetPin(resetPin), .parIn(parIn), .failsafeSelectPin(fsPin),
        .vddFail(zero1), .currentTripFlags(tripOc), .thermalTripFlags(zero4),
        .shortTripFlags(zero4), .lowSupplyFlag(zero1), .highSupplyFlag(zero1),
        .loadSwitchOutputs(outs), .faultRearm(rearm), .modeState(modeState),
        .normalModeFlag(nmFlag), .clockFailFlag(clkFail));

    // ********************************
    // Access and check tasks
    // ********************************
    task automatic results();
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic spi(input logic [15:0] w);
        host.xfer(w, rxWord);
    endtask

    task automatic waitMode(input logic [3:0] e, input int lim);
        int n;
        n = 0;
        while (modeState !== e && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        `CHK("modeState", e, modeState)
        if (n >= lim) results();
    endtask

    // ********************************
    // Test sequence
    // ********************************
    initial begin
        cyc(16);
        rstn = 1'b1;
        cyc(6);
        waitMode(4'h1, 4);
        `CHK("outs", 4'h0, outs)
        $display("test reset done");
        wakePin = 1'b1;
        waitMode(4'h2, 20);
        `CHK("nmFlag", 1'b1, nmFlag)
        parIn = 4'b0110;
        spi(16'h8041);
        cyc(20);
        `CHK("outs", 4'h3, outs)
        `CHK("rearm", 4'h3, rearm)
        spi(16'h0041);
        `CHK("status nm", 1'b1, rxWord[15])
        `CHK("status mode", 2'b01, rxWord[13:12])
        $display("test direct drive done");
        spi(16'h5a5c);
        host.calPulse(100);
        spi(16'h0041);
        `CHK("cal short", 1'b0, rxWord[8])
        spi(16'h5a5c);
        host.calPulse(700);
        spi(16'h0041);
        `CHK("cal valid", 1'b1, rxWord[8])
        $display("test calibration done");
        // Calibrated tick is 700/128 = 5 clocks, so one PWM period is 640 clocks
        spi(16'h0341);
        for (int k = 0; k < 4; k++) begin
            spi({4'h1, 5'h00, (k == 3) ? 7'h7f : (7'h07 * k[6:0] * k[6:0] - 7'h00)});
            cyc(700);
            cnt = 0;
            repeat (640) begin
                @(negedge core_clk);
                if (outs[0] === 1'b1) cnt++;
            end
            `CHK("pwm high", (k == 3) ? 640 : (7 * k * k + 1) * 5, cnt)
        end
        `CHK("other outs", 3'h0, outs[3:1])
        $display("test pwm done");
        tripOc = 4'h1;
        waitMode(4'h8, 20);
        tripOc = 4'h0;
        cyc(10);
        $display("test fault done");
        wakePin = 1'b0;
        parIn = 4'h0;
        waitMode(4'h1, 40);
        wakePin = 1'b1;
        waitMode(4'h2, 20);
        cyc(20);
        `CHK("outs", 4'h0, outs)
        $display("test sleep done");
        wakePin = 1'b0;
        waitMode(4'h1, 40);
        fsPin = 1'b1;
        cyc(4);
        wakePin = 1'b1;
        waitMode(4'h2, 20);
        waitMode(4'h4, WATCHDOG_TIMEOUT_PERIOD + 100);
        `CHK("nmFlag", 1'b0, nmFlag)
        parIn = 4'b0100;
        spi(16'h0000);
        `CHK("status mode", 2'b10, rxWord[13:12])
        `CHK("outs", 4'h4, outs)
        spi(16'h8000);
        waitMode(4'h2, 20);
        for (int k = 0; k < 4; k++) begin
            spi({k[0], 15'h0000});
            cyc(1500);
        end
        `CHK("modeState", 4'h2, modeState)
        $display("test watchdog done");
        // No clock was ever applied on input 0, so the window check must fail
        `CHK("clkFail", 1'b1, clkFail)
        $display("test clock monitor done");
        results();
    end
endmodule // lsmpc_core_bench
